/* File: core/tpss_pkg.sv */
// What this block does
// - Six outputs form three phases; each one-hot steer code drives one high/low pair.
// - Steer codes with several bits set use the lowest set bit's pair.
// - High-side enable lets the active high output follow rise and fall events.
// - Low-side enable lets the active low output follow rise and fall events.
// - Both enables clear puts active outputs at their rise state and holds them.
// - A rise event drives every modulated active output to its active level.
// - A fall event with no rise in the same cycle drives every modulated active output to its inactive level.
// - Sync source 100 takes the sibling sync output, 011 takes our own.
package tpss_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] TPSS_OFS_STEER  = 4'h0;
    localparam logic [3:0] TPSS_OFS_MODEN  = 4'h4;
    localparam logic [3:0] TPSS_OFS_SYNC   = 4'h8;
    localparam logic [3:0] TPSS_OFS_STATUS = 4'hc;

    localparam logic [5:0] TPSS_STEER_RST  = 6'h00;
    localparam logic [1:0] TPSS_MODEN_RST  = 2'h0;
    localparam logic [7:0] TPSS_SYNC_RST   = 8'h00;
    localparam logic [7:0] TPSS_SYNC_WMASK = 8'he7;

    localparam int TPSS_MOD_HS_BIT   = 0;
    localparam int TPSS_MOD_LS_BIT   = 1;
    localparam int TPSS_POFST_BIT    = 7;
    localparam int TPSS_PRPOL_BIT    = 6;
    localparam int TPSS_DCPOL_BIT    = 5;
    localparam int TPSS_SRC_LSB      = 0;
    localparam int TPSS_STAT_LAT_BIT = 6;
    localparam int TPSS_STAT_SYN_BIT = 7;

    localparam logic [2:0] TPSS_SRC_SIBLING = 3'b100;
    localparam logic [2:0] TPSS_SRC_SELF    = 3'b011;

    // ----------------------------------------------------------------
    // Output pairs, bit order F E D C B A
    // ----------------------------------------------------------------
    localparam logic [5:0] TPSS_HIGH_MASK = 6'h15;
    localparam logic [5:0] TPSS_LOW_MASK  = 6'h2a;
    localparam logic [5:0] TPSS_PAIR_TBL [6] = '{6'h09, 6'h21, 6'h24, 6'h06, 6'h12, 6'h18};

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic period;
        logic phase;
        logic duty;
        logic sibling;
    } tpss_evt_t;

    typedef struct packed {
        logic       pofst;
        logic       prpol;
        logic       dcpol;
        logic [2:0] src;
    } tpss_ctrl_t;

    function automatic logic [5:0] tpss_pair_mask(input logic [5:0] steer);
        logic [5:0] m;
        m = 6'h00;
        for (int i = 5; i >= 0; i--)
        begin
            if (steer[i])
            begin
                m = TPSS_PAIR_TBL[i];
            end
        end
        return m;
    endfunction : tpss_pair_mask

endpackage : tpss_pkg

/* File: core/tpss_steer_decode.sv */
`timescale 1ns/100ps
module tpss_steer_decode (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [5:0] steer,
    output logic      [5:0] pair_mask
);
    import tpss_pkg::*;

    assign pair_mask = tpss_pair_mask(steer);

    property p_multi_lowest;
        @(posedge clk) disable iff (srst)
        (steer == 6'h0c) |-> (pair_mask == 6'h24);
    endproperty
    a_multi_lowest: assert property (p_multi_lowest) else $error("lowest steer bit lost");

endmodule : tpss_steer_decode

/* File: core/tpss_sync_mux.sv */
`timescale 1ns/100ps
module tpss_sync_mux (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire tpss_pkg::tpss_ctrl_t ctrl,
    input  wire tpss_pkg::tpss_evt_t  evt,
    output logic                     sync_out_p,
    output logic                     sync_in_p,
    output logic                     latch_set_p
);
    import tpss_pkg::*;

    // Codes 001 and 010 are not implemented and fall back to the period event.
    assign sync_out_p  = ctrl.pofst ? evt.phase : evt.period;
    assign sync_in_p   = (ctrl.src == TPSS_SRC_SIBLING) ? evt.sibling :
                         (ctrl.src == TPSS_SRC_SELF)    ? sync_out_p  : evt.period;
    assign latch_set_p = ctrl.pofst ? sync_in_p : evt.phase;

    property p_src_sibling;
        @(posedge clk) disable iff (srst)
        (ctrl.src == 3'b100) |-> (sync_in_p == evt.sibling);
    endproperty
    a_src_sibling: assert property (p_src_sibling) else $error("sibling sync not routed");

    property p_pofst_swap;
        @(posedge clk) disable iff (srst)
        (ctrl.pofst && ctrl.src == 3'b011) |-> (latch_set_p == evt.phase);
    endproperty
    a_pofst_swap: assert property (p_pofst_swap) else $error("phase offset swap wrong");

endmodule : tpss_sync_mux

/* File: core/tpss_top.sv */
`timescale 1ns/100ps
module tpss_top (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        period_evt_pin,
    input  wire logic        phase_evt_pin,
    input  wire logic        duty_evt_pin,
    input  wire logic        sibling_sync_pin,
    output logic             phase1_high_out,
    output logic             phase1_low_out,
    output logic             phase2_high_out,
    output logic             phase2_low_out,
    output logic             phase3_high_out,
    output logic             phase3_low_out,
    output logic             sync_out
);
    import tpss_pkg::*;

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    logic [5:0]  phase_steer_select_r;
    logic [1:0]  steer_control_one_r;
    logic [7:0]  period_sync_control_r;
    logic        ack_r;
    logic [31:0] rdata_r;
    logic        req;
    logic        take;
    logic [5:0]  out_r;
    logic        latch_r;
    logic        sync_out_r;

    assign req             = avs_read | avs_write;
    assign take            = req & ~ack_r;
    // One wait cycle lets the read data come from a flip-flop.
    assign avs_waitrequest = req & ~ack_r;
    assign avs_readdata    = rdata_r;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ack_r <= 1'b0;
        end
        else
        begin
            ack_r <= take;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            phase_steer_select_r  <= TPSS_STEER_RST;
            steer_control_one_r   <= TPSS_MODEN_RST;
            period_sync_control_r <= TPSS_SYNC_RST;
        end
        // A write lands only on the edge at which the master sees waitrequest low.
        else if (ack_r && avs_write && avs_byteenable[0])
        begin
            unique case (avs_address)
                TPSS_OFS_STEER: phase_steer_select_r <= avs_writedata[5:0];
                TPSS_OFS_MODEN: steer_control_one_r  <= avs_writedata[1:0];
                TPSS_OFS_SYNC:  period_sync_control_r <= avs_writedata[7:0] & TPSS_SYNC_WMASK;
                default:        ;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rdata_r <= 32'h0000_0000;
        end
        else if (take && avs_read)
        begin
            unique case (avs_address)
                TPSS_OFS_STEER:  rdata_r <= {26'h0, phase_steer_select_r};
                TPSS_OFS_MODEN:  rdata_r <= {30'h0, steer_control_one_r};
                TPSS_OFS_SYNC:   rdata_r <= {24'h0, period_sync_control_r};
                TPSS_OFS_STATUS: rdata_r <= {24'h0, sync_out_r, latch_r, out_r};
                default:         rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    tpss_ctrl_t ctrl;
    logic       high_side_mod_enable;
    logic       low_side_mod_enable;

    assign high_side_mod_enable = steer_control_one_r[TPSS_MOD_HS_BIT];
    assign low_side_mod_enable  = steer_control_one_r[TPSS_MOD_LS_BIT];
    assign ctrl.pofst = period_sync_control_r[TPSS_POFST_BIT];
    assign ctrl.prpol = period_sync_control_r[TPSS_PRPOL_BIT];
    assign ctrl.dcpol = period_sync_control_r[TPSS_DCPOL_BIT];
    assign ctrl.src   = period_sync_control_r[TPSS_SRC_LSB +: 3];

    // ----------------------------------------------------------------
    // Event inputs
    // ----------------------------------------------------------------
    tpss_evt_t pin_raw;
    tpss_evt_t meta_r;
    tpss_evt_t sync_r;
    tpss_evt_t lvl;
    tpss_evt_t prev_r;
    tpss_evt_t evt_p;

    assign pin_raw = '{period: period_evt_pin, phase: phase_evt_pin,
                       duty: duty_evt_pin, sibling: sibling_sync_pin};

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= pin_raw;
            sync_r <= meta_r;
        end
    end

    // Only the selected period and duty inputs are affected by the invert bits.
    assign lvl.period  = sync_r.period ^ ctrl.prpol;
    assign lvl.duty    = sync_r.duty ^ ctrl.dcpol;
    assign lvl.phase   = sync_r.phase;
    assign lvl.sibling = sync_r.sibling;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            prev_r <= '0;
        end
        else
        begin
            prev_r <= lvl;
        end
    end

    // Toggling an invert bit can itself look like an edge; change it while idle.
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_edge
            assign evt_p[g] = lvl[g] & ~prev_r[g];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Synchronization and steering
    // ----------------------------------------------------------------
    logic       sync_out_p;
    logic       sync_in_p;
    logic       set_p;
    logic       fall_p;
    logic [5:0] pair_mask;
    logic [5:0] mod_mask;
    logic [5:0] out_nxt;

    tpss_sync_mux u_sync (
        .clk         (clk),
        .srst        (srst),
        .ctrl        (ctrl),
        .evt         (evt_p),
        .sync_out_p  (sync_out_p),
        .sync_in_p   (sync_in_p),
        .latch_set_p (set_p)
    );

    tpss_steer_decode u_steer (
        .clk       (clk),
        .srst      (srst),
        .steer     (phase_steer_select_r),
        .pair_mask (pair_mask)
    );

    assign fall_p = evt_p.duty;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sync_out_r <= 1'b0;
        end
        else
        begin
            sync_out_r <= sync_out_p;
        end
    end

    // A rise and a fall in the same cycle leave the output set.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            latch_r <= 1'b0;
        end
        else if (set_p)
        begin
            latch_r <= 1'b1;
        end
        else if (fall_p)
        begin
            latch_r <= 1'b0;
        end
    end

    assign mod_mask = (high_side_mod_enable ? TPSS_HIGH_MASK : 6'h00) |
                      (low_side_mod_enable  ? TPSS_LOW_MASK  : 6'h00);
    // Unmodulated active outputs sit at their rise state.
    assign out_nxt  = pair_mask & (~mod_mask | {6{latch_r}});

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            out_r <= 6'h00;
        end
        else
        begin
            out_r <= out_nxt;
        end
    end

    assign phase1_high_out = out_r[0];
    assign phase1_low_out  = out_r[1];
    assign phase2_high_out = out_r[2];
    assign phase2_low_out  = out_r[3];
    assign phase3_high_out = out_r[4];
    assign phase3_low_out  = out_r[5];
    assign sync_out        = sync_out_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_one_pair;
        @(posedge clk) disable iff (srst)
        (phase_steer_select_r == 6'h20 && steer_control_one_r == 2'h0)
            |=> (out_r == 6'h18);
    endproperty
    a_one_pair: assert property (p_one_pair) else $error("steer 20h pair wrong");

    property p_hs_fall;
        @(posedge clk) disable iff (srst)
        (fall_p && !set_p && high_side_mod_enable && $stable(steer_control_one_r))
            ##1 (!set_p && high_side_mod_enable) |=> ((out_r & TPSS_HIGH_MASK) == 6'h00);
    endproperty
    a_hs_fall: assert property (p_hs_fall) else $error("high side not modulated");

    property p_ls_fall;
        @(posedge clk) disable iff (srst)
        (fall_p && !set_p && low_side_mod_enable)
            ##1 (!set_p && low_side_mod_enable) |=> ((out_r & TPSS_LOW_MASK) == 6'h00);
    endproperty
    a_ls_fall: assert property (p_ls_fall) else $error("low side not modulated");

    property p_hold;
        @(posedge clk) disable iff (srst)
        (steer_control_one_r == 2'h0) |=> (out_r == $past(pair_mask));
    endproperty
    a_hold: assert property (p_hold) else $error("unmodulated outputs not held");

    property p_rise;
        @(posedge clk) disable iff (srst)
        (set_p ##1 $stable(pair_mask)) |=> (out_r == $past(pair_mask));
    endproperty
    a_rise: assert property (p_rise) else $error("rise did not set outputs");

    property p_fall;
        @(posedge clk) disable iff (srst)
        (fall_p && !set_p) |=> !latch_r;
    endproperty
    a_fall: assert property (p_fall) else $error("fall did not clear latch");

    property p_duty_pol;
        @(posedge clk) disable iff (srst)
        ((sync_r.duty != ctrl.dcpol) && ($past(sync_r.duty) == ctrl.dcpol) && $stable(ctrl.dcpol))
            |-> fall_p;
    endproperty
    a_duty_pol: assert property (p_duty_pol) else $error("duty polarity wrong");

endmodule : tpss_top

/* File: testbench/three_phase_steering_sync_tb.sv */
`timescale 1ns/100ps
module three_phase_steering_sync_tb;
    import tpss_pkg::*;
    logic        clk = 1'b0;
    logic        srst, avs_read, avs_write, prd, phs, dty, sib;
    logic        avs_waitrequest, sync_out;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [5:0]  outs;
    logic [2:0]  shoot, node_hi;
    int          fails, checked, cyc, syncs, s0;

    // ----------------------------------------------------------------
    // Design and far side
    // ----------------------------------------------------------------
    tpss_top dut_u (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .period_evt_pin(prd), .phase_evt_pin(phs), .duty_evt_pin(dty), .sibling_sync_pin(sib),
        .phase1_high_out(outs[0]), .phase1_low_out(outs[1]), .phase2_high_out(outs[2]),
        .phase2_low_out(outs[3]), .phase3_high_out(outs[4]), .phase3_low_out(outs[5]),
        .sync_out(sync_out));
    tpss_gate_model gate_u (.gate(outs), .shoot_thru(shoot), .node_high(node_hi));

    always #12.5 clk = ~clk;

    // A one-cycle sync pulse is easy to miss by polling, so every pulse is counted here.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (sync_out === 1'b1)
            syncs <= syncs + 1;
        if (cyc == 20000)
        begin
            fails = fails + 1;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task print_verdict;
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // Waitrequest is read right after the rising edge, before that edge's updates land.
    task bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic be0);
        @(posedge clk);
        avs_address    <= a;
        avs_writedata  <= {24'h000000, d};
        avs_byteenable <= {3'h0, be0};
        avs_read       <= !wr;
        avs_write      <= wr;
        do
        begin
            @(posedge clk);
        end
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task set_steer(input logic [5:0] c);
        bus(1'b1, TPSS_OFS_STEER, {2'h0, c}, 1'b1);
        idle(4);
    endtask : set_steer

    task pins(input logic p, input logic ph, input logic d, input logic s);
        @(posedge clk);
        prd <= p;
        phs <= ph;
        dty <= d;
        sib <= s;
        idle(8);
    endtask : pins

    task pulse_phase;
        pins(1'b0, 1'b1, 1'b0, 1'b0);
        pins(1'b0, 1'b0, 1'b0, 1'b0);
    endtask : pulse_phase

    task fall_duty;
        pins(1'b0, 1'b0, 1'b1, 1'b0);
        pins(1'b0, 1'b0, 1'b0, 1'b0);
    endtask : fall_duty

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_reset;
        chk("outs_rst", {26'h0, outs}, 32'h0);
        bus(1'b0, TPSS_OFS_STEER, 8'h00, 1'b1);
        chk("steer_rst", q, 32'h0);
        bus(1'b0, TPSS_OFS_MODEN, 8'h00, 1'b1);
        chk("moden_rst", q, 32'h0);
        bus(1'b0, TPSS_OFS_SYNC, 8'h00, 1'b1);
        chk("sync_rst", q, 32'h0);
        bus(1'b0, 4'h2, 8'h00, 1'b1);
        chk("unmapped", q, 32'h0);
    endtask : t_reset

    // The source field is given the defined code 100, and code 000 by the 00h write; the 03h write has byteenable 0 and is dropped.
    task t_regs;
        bus(1'b1, TPSS_OFS_SYNC, 8'hfc, 1'b1);
        bus(1'b0, TPSS_OFS_SYNC, 8'h00, 1'b1);
        chk("sync_rw", q, 32'he4);
        bus(1'b1, TPSS_OFS_SYNC, 8'h03, 1'b0);
        bus(1'b0, TPSS_OFS_SYNC, 8'h00, 1'b1);
        chk("sync_be", q, 32'he4);
        bus(1'b1, TPSS_OFS_SYNC, 8'h00, 1'b1);
        bus(1'b1, TPSS_OFS_STATUS, 8'hff, 1'b1);
        bus(1'b0, TPSS_OFS_STATUS, 8'h00, 1'b1);
        chk("status_ro", q, 32'h0);
    endtask : t_regs

    task t_steer;
        logic [5:0] code [7];
        logic [5:0] exp [7];
        logic [2:0] hi [7];
        code = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
        exp  = '{6'h00, 6'h09, 6'h21, 6'h24, 6'h06, 6'h12, 6'h18};
        hi   = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
        for (int i = 0; i < 7; i++)
        begin
            set_steer(code[i]);
            chk("steer_pair", {26'h0, outs}, {26'h0, exp[i]});
            chk("shoot", {29'h0, shoot}, 32'h0);
            chk("node_high", {29'h0, node_hi}, {29'h0, hi[i]});
        end
    endtask : t_steer

    task t_multi;
        logic [5:0] code [5];
        logic [5:0] exp [5];
        code = '{6'h03, 6'h0c, 6'h30, 6'h3f, 6'h06};
        exp  = '{6'h09, 6'h24, 6'h12, 6'h09, 6'h21};
        for (int i = 0; i < 5; i++)
        begin
            set_steer(code[i]);
            chk("steer_multi", {26'h0, outs}, {26'h0, exp[i]});
        end
    endtask : t_multi

    task t_mod;
        bus(1'b1, TPSS_OFS_MODEN, 8'h01, 1'b1);
        set_steer(6'h01);
        fall_duty();
        chk("hs_fall", {26'h0, outs}, 32'h08);
        pulse_phase();
        chk("hs_rise", {26'h0, outs}, 32'h09);
        fall_duty();
        chk("hs_fall2", {26'h0, outs}, 32'h08);
        bus(1'b1, TPSS_OFS_MODEN, 8'h02, 1'b1);
        idle(4);
        chk("ls_idle", {26'h0, outs}, 32'h01);
        pulse_phase();
        chk("ls_rise", {26'h0, outs}, 32'h09);
        fall_duty();
        chk("ls_fall", {26'h0, outs}, 32'h01);
    endtask : t_mod

    task t_sync;
        bus(1'b1, TPSS_OFS_MODEN, 8'h01, 1'b1);
        bus(1'b1, TPSS_OFS_SYNC, 8'h84, 1'b1);
        fall_duty();
        s0 = syncs;
        pulse_phase();
        chk("ofs_sync", 32'(syncs - s0), 32'h1);
        chk("ofs_nolatch", {26'h0, outs}, 32'h08);
        s0 = syncs;
        pins(1'b0, 1'b0, 1'b0, 1'b1);
        pins(1'b0, 1'b0, 1'b0, 1'b0);
        chk("sib_latch", {26'h0, outs}, 32'h09);
        chk("sib_nosync", 32'(syncs - s0), 32'h0);
        fall_duty();
        bus(1'b1, TPSS_OFS_SYNC, 8'h83, 1'b1);
        pulse_phase();
        chk("self_latch", {26'h0, outs}, 32'h09);
        bus(1'b1, TPSS_OFS_SYNC, 8'h03, 1'b1);
        fall_duty();
        s0 = syncs;
        pins(1'b1, 1'b0, 1'b0, 1'b0);
        pins(1'b0, 1'b0, 1'b0, 1'b0);
        chk("prd_sync", 32'(syncs - s0), 32'h1);
        chk("prd_nolatch", {26'h0, outs}, 32'h08);
        pulse_phase();
        chk("phs_latch", {26'h0, outs}, 32'h09);
    endtask : t_sync

    // Flipping an invert bit can itself raise an event, so the outputs are set afresh after it.
    task t_pol;
        bus(1'b1, TPSS_OFS_SYNC, 8'h43, 1'b1);
        idle(8);
        s0 = syncs;
        pins(1'b1, 1'b0, 1'b0, 1'b0);
        chk("prd_inv_rise", 32'(syncs - s0), 32'h0);
        pins(1'b0, 1'b0, 1'b0, 1'b0);
        chk("prd_inv_fall", 32'(syncs - s0), 32'h1);
        bus(1'b1, TPSS_OFS_SYNC, 8'h23, 1'b1);
        idle(8);
        pulse_phase();
        chk("dc_inv_hold", {26'h0, outs}, 32'h09);
        pins(1'b0, 1'b0, 1'b1, 1'b0);
        chk("dc_inv_fall", {26'h0, outs}, 32'h09);
        pins(1'b0, 1'b0, 1'b0, 1'b0);
        chk("dc_inv_rise", {26'h0, outs}, 32'h08);
    endtask : t_pol

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        srst = 1'b1;
        {avs_read, avs_write, prd, phs, dty, sib} = 6'h00;
        avs_address = 4'h0;
        avs_byteenable = 4'h0;
        avs_writedata = 32'h0;
        fails = 0;
        checked = 0;
        cyc = 0;
        syncs = 0;
        idle(10);
        srst <= 1'b0;
        idle(2);
        t_reset();
        t_regs();
        t_steer();
        t_multi();
        t_mod();
        t_sync();
        t_pol();
        print_verdict();
    end
endmodule : three_phase_steering_sync_tb

/* File: testbench/tpss_gate_model.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Gate drivers of three half-bridges
// ----------------------------------------------------------------
// Both devices of one bridge on at once shorts the rail, so each phase is flagged.
module tpss_gate_model (
    input  wire logic [5:0] gate,
    output logic      [2:0] shoot_thru,
    output logic      [2:0] node_high
);
    always_comb
    begin
        for (int p = 0; p < 3; p++)
        begin
            shoot_thru[p] = gate[2*p] & gate[2*p+1];
            node_high[p]  = gate[2*p] & ~gate[2*p+1];
        end
    end
endmodule : tpss_gate_model
